// file: src/pse_engine.sv
`default_nettype none
module pse_engine #(
  parameter int unsigned CLK_PER_US = pse_pkg::CLK_HZ / 1_000_000
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // axi4-lite write address and data
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // axi4-lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic      [1:0]  bresp,
  // axi4-lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  // supply fault detector and warning pins
  input  wire logic [9:0]  sfdUnder,
  input  wire logic [9:0]  sfdOver,
  input  wire logic [9:0]  limitWarn,
  input  wire logic [9:0]  secondWarn,
  // driver outputs and engine state
  output logic      [9:0]  drvOut,
  output logic      [5:0]  curState
);
  typedef struct packed {
    pse_pkg::pse_eng_t eng;
    logic [5:0]  cur;
    logic [5:0]  nxt;
    logic [9:0]  loadCnt;
    logic [63:0] def;
    logic [9:0]  drv;
    logic [10:0] fault;
    logic        run;
    logic        jump;
    logic [5:0]  defIdx;
    logic [31:0] defLow;
    logic        awHeld;
    logic        wHeld;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } pse_engine_t;
  pse_engine_t q, next_q;

  logic        rstSync;
  logic [39:0] pinSync;
  logic [9:0]  uvLive;
  logic [9:0]  ovLive;
  logic [9:0]  limLive;
  logic [9:0]  secLive;
  logic        warn;
  logic [10:0] inLive;
  logic [3:0]  seqSel;
  logic        seqCond;
  logic        seqDone;
  logic        toDone;
  logic        monHit;
  logic        seqHit;
  logic        toHit;
  logic [23:0] seqLimit;
  logic [23:0] toLimit;
  logic        wrFire;
  logic        defCommit;
  logic [63:0] defMem [pse_pkg::NUM_STATES];

  function automatic logic [23:0] usToCyc(input int unsigned us);
    return 24'(us * CLK_PER_US);
  endfunction

  // reset release through two flops
  pse_sync #(.W(1)) uRstSync (
    .clk  (ref_clk),
    .rstn (rstn),
    .din  (1'b1),
    .dout (rstSync)
  );

  // pin inputs through two flops
  pse_sync #(.W(40)) uPinSync (
    .clk  (ref_clk),
    .rstn (rstSync),
    .din  ({secondWarn, limitWarn, sfdOver, sfdUnder}),
    .dout (pinSync)
  );

  // live input vector: supply ok bits plus warning
  assign uvLive  = pinSync[9:0];
  assign ovLive  = pinSync[19:10];
  assign limLive = pinSync[29:20];
  assign secLive = pinSync[39:30];
  assign warn    = |{limLive, secLive};
  assign inLive  = {warn, ~uvLive & ~ovLive};

  // exit detectors on the loaded definition
  assign seqSel  = q.def[pse_pkg::F_SEQSEL +: 4];
  assign seqCond = (seqSel < 4'(pse_pkg::NUM_IN)) &&
                   (inLive[seqSel] == q.def[pse_pkg::F_SEQPOL]);
  assign seqLimit =
    usToCyc(pse_pkg::SEQ_US[q.def[pse_pkg::F_SEQDLY +: 4]]);
  assign toLimit =
    usToCyc(pse_pkg::TO_US[q.def[pse_pkg::F_TODLY +: 4]]);
  assign monHit = (q.eng == pse_pkg::ENG_RUN) &&
                  |(q.def[pse_pkg::F_MASK +: 11] &
                    (inLive ^ q.def[pse_pkg::F_EXP +: 11]));
  assign seqHit = seqDone || q.jump;
  assign toHit  = (q.def[pse_pkg::F_TODLY +: 4] == 4'h0) ? warn
                                                       : toDone;

  // qualification timer restarts whenever the input leaves its level
  pse_delay_timer uSeqTimer (
    .clk     (ref_clk),
    .rstn    (rstSync),
    .restart ((q.eng != pse_pkg::ENG_RUN) || !seqCond),
    .limit   (seqLimit),
    .done    (seqDone)
  );

  // timeout runs from state entry
  pse_delay_timer uToTimer (
    .clk     (ref_clk),
    .rstn    (rstSync),
    .restart (q.eng != pse_pkg::ENG_RUN),
    .limit   (toLimit),
    .done    (toDone)
  );

  // bus write completes once address and data are both held
  assign wrFire    = q.awHeld && q.wHeld && !q.bvalid;
  assign defCommit = wrFire && (q.awAddr == pse_pkg::REG_DEF_HIGH) &&
                     (q.defIdx < 6'(pse_pkg::NUM_STATES));

  // definition store, one word per state
  always_ff @(posedge ref_clk) begin
    if (defCommit) begin
      defMem[q.defIdx] <= {q.wData, q.defLow};
    end
  end

  always_comb begin
    logic [10:0] fltClr;
    logic [10:0] fltSet;
    logic [5:0]  tgt;
    logic        leave;
    fltClr = '0;
    fltSet = '0;
    tgt    = '0;
    leave  = 1'b0;
    next_q = q;
    // write channels
    if (awvalid && awready) begin
      next_q.awHeld = 1'b1;
      next_q.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_q.wHeld = 1'b1;
      next_q.wData = wdata;
    end
    if (q.bvalid && bready) begin
      next_q.bvalid = 1'b0;
    end
    if (wrFire) begin
      next_q.awHeld = 1'b0;
      next_q.wHeld  = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp  = pse_pkg::RESP_OKAY;
      unique case (q.awAddr)
        pse_pkg::REG_CTRL: begin
          next_q.run = q.wData[0];
          if (q.wData[1]) begin
            next_q.jump = 1'b1;
          end
        end
        pse_pkg::REG_FLT_LOW:  fltClr[7:0]  = q.wData[7:0];
        pse_pkg::REG_FLT_HIGH: fltClr[10:8] = q.wData[2:0];
        pse_pkg::REG_DEF_IDX:  next_q.defIdx = q.wData[5:0];
        pse_pkg::REG_DEF_LOW:  next_q.defLow = q.wData;
        pse_pkg::REG_DEF_HIGH: next_q.defLow = q.defLow;
        pse_pkg::REG_STATE, pse_pkg::REG_STAT_SUP,
        pse_pkg::REG_STAT_LIM: next_q.bresp = pse_pkg::RESP_OKAY;
        default:               next_q.bresp = pse_pkg::RESP_SLVERR;
      endcase
    end
    // read channel
    if (q.rvalid && rready) begin
      next_q.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_q.rvalid = 1'b1;
      next_q.rresp  = pse_pkg::RESP_OKAY;
      next_q.rdata  = '0;
      unique case (araddr)
        pse_pkg::REG_CTRL:     next_q.rdata[1:0] = {q.jump, q.run};
        pse_pkg::REG_STATE:    next_q.rdata = {6'h00, q.drv, 6'h00,
          q.eng == pse_pkg::ENG_RUN, q.eng == pse_pkg::ENG_LOAD, 2'b00,
          q.cur};
        pse_pkg::REG_FLT_LOW:  next_q.rdata[7:0] = q.fault[7:0];
        pse_pkg::REG_FLT_HIGH: next_q.rdata[2:0] = q.fault[10:8];
        pse_pkg::REG_STAT_SUP: next_q.rdata = {6'h00, ovLive, 6'h00,
                                               uvLive};
        pse_pkg::REG_STAT_LIM: next_q.rdata = {6'h00, secLive, 6'h00,
                                               limLive};
        pse_pkg::REG_DEF_IDX:  next_q.rdata[5:0] = q.defIdx;
        pse_pkg::REG_DEF_LOW:  next_q.rdata = q.defLow;
        pse_pkg::REG_DEF_HIGH: next_q.rdata =
          (q.defIdx < 6'(pse_pkg::NUM_STATES)) ? defMem[q.defIdx][63:32]
                                                : 32'h00000000;
        default:               next_q.rresp = pse_pkg::RESP_SLVERR;
      endcase
    end
    // engine sequencing
    unique case (q.eng)
      pse_pkg::ENG_IDLE: begin
        next_q.jump = 1'b0;
        if (q.run) begin
          next_q.nxt     = pse_pkg::FIRST_STATE;
          next_q.loadCnt = '0;
          next_q.eng     = pse_pkg::ENG_LOAD;
        end
      end
      pse_pkg::ENG_LOAD: begin
        next_q.loadCnt = q.loadCnt + 10'h001;
        if (q.loadCnt == 10'(pse_pkg::LOAD_CYC - 1)) begin
          next_q.def = defMem[q.nxt];
          next_q.drv = defMem[q.nxt][pse_pkg::F_DRV +: 10];
          next_q.cur = q.nxt;
          next_q.eng = pse_pkg::ENG_RUN;
        end
      end
      pse_pkg::ENG_RUN: begin
        if (monHit) begin
          tgt   = q.def[pse_pkg::F_MONNXT +: 6];
          leave = 1'b1;
        end else if (seqHit) begin
          tgt         = q.def[pse_pkg::F_SEQNXT +: 6];
          leave       = 1'b1;
          next_q.jump = 1'b0;
        end else if (toHit) begin
          tgt   = q.def[pse_pkg::F_TONXT +: 6];
          leave = 1'b1;
        end
        if (!q.run) begin
          next_q.eng = pse_pkg::ENG_IDLE;
        end else if (leave && tgt == pse_pkg::HALT_STATE) begin
          next_q.eng = pse_pkg::ENG_IDLE;
          next_q.run = 1'b0;
        end else if (leave) begin
          next_q.nxt     = tgt;
          next_q.loadCnt = '0;
          next_q.eng     = pse_pkg::ENG_LOAD;
        end
        if (q.def[pse_pkg::F_LATCH]) begin
          fltSet = ~inLive;
          fltSet[10] = warn;
        end
      end
      default: next_q.eng = pse_pkg::ENG_IDLE;
    endcase
    // a new fault wins over a clear in the same cycle
    next_q.fault = (q.fault & ~fltClr) | fltSet;
  end

  always_ff @(posedge ref_clk or negedge rstSync) begin
    if (!rstSync) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // bus handshakes and outputs
  assign awready  = !q.awHeld && !q.bvalid;
  assign wready   = !q.wHeld && !q.bvalid;
  assign arready  = !q.rvalid;
  assign bvalid   = q.bvalid;
  assign bresp    = q.bresp;
  assign rvalid   = q.rvalid;
  assign rdata    = q.rdata;
  assign rresp    = q.rresp;
  assign drvOut   = q.drv;
  assign curState = q.cur;
endmodule // pse_engine
`default_nettype wire

// file: src/pse_pkg.sv
`default_nettype none
package pse_pkg;
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned NUM_SUP    = 10;
  localparam int unsigned NUM_IN     = 11;
  localparam int unsigned NUM_STATES = 63;
  localparam logic [5:0]  HALT_STATE = 6'h3f;
  localparam logic [5:0]  FIRST_STATE = 6'h00;
  // definition load time
  localparam int unsigned LOAD_US  = 20;
  localparam int unsigned LOAD_CYC = (LOAD_US * CLK_HZ) / 1_000_000;
  // definition word fields
  localparam int unsigned F_DRV    = 0;
  localparam int unsigned F_SEQSEL = 10;
  localparam int unsigned F_SEQPOL = 14;
  localparam int unsigned F_SEQNXT = 15;
  localparam int unsigned F_MONNXT = 21;
  localparam int unsigned F_TONXT  = 27;
  localparam int unsigned F_MASK   = 33;
  localparam int unsigned F_EXP    = 44;
  localparam int unsigned F_LATCH  = 55;
  localparam int unsigned F_SEQDLY = 56;
  localparam int unsigned F_TODLY  = 60;
  // delay codes in microseconds
  localparam int unsigned SEQ_US [16] = '{0, 10, 20, 50, 100, 200, 500,
    1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000, 400000};
  localparam int unsigned TO_US [16] = '{0, 100, 200, 500, 1000, 2000,
    5000, 10000, 20000, 50000, 100000, 150000, 200000, 250000, 300000,
    400000};
  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATE    = 8'h04;
  localparam logic [7:0] REG_FLT_LOW  = 8'h08;
  localparam logic [7:0] REG_FLT_HIGH = 8'h0c;
  localparam logic [7:0] REG_STAT_SUP = 8'h10;
  localparam logic [7:0] REG_STAT_LIM = 8'h14;
  localparam logic [7:0] REG_DEF_IDX  = 8'h18;
  localparam logic [7:0] REG_DEF_LOW  = 8'h1c;
  localparam logic [7:0] REG_DEF_HIGH = 8'h20;
  localparam int unsigned FLT_LOW_W = 8;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {ENG_IDLE, ENG_LOAD, ENG_RUN} pse_eng_t;
endpackage
`default_nettype wire

// file: src/pse_sync.sv
`default_nettype none
module pse_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // levels in and out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pse_sync_t;
  pse_sync_t q, next_q;

  // two stage chain, second stage only reads the first
  always_comb begin
    next_q.s1 = din;
    next_q.s2 = q.s1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign dout = q.s2;
endmodule // pse_sync
`default_nettype wire

// file: src/pse_delay_timer.sv
`default_nettype none
module pse_delay_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // control
  input  wire logic        restart,
  input  wire logic [23:0] limit,
  // result
  output logic             done
);
  typedef struct packed {
    logic [23:0] cnt;
  } pse_tmr_t;
  pse_tmr_t q, next_q;

  // count up to limit, saturate, clear on restart
  always_comb begin
    next_q = q;
    if (restart) begin
      next_q.cnt = '0;
    end else if (q.cnt != limit) begin
      next_q.cnt = q.cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign done = !restart && (q.cnt == limit);
endmodule // pse_delay_timer
`default_nettype wire

// file: tb/pse_supply_model.sv
`default_nettype none
module pse_supply_model #(
  parameter int unsigned LAG = 1
) (
  // clock
  input  wire logic        ref_clk,
  // wanted {second, limit, over, under}
  input  wire logic [39:0] want,
  // comparator and warning outputs
  output logic      [9:0]  sfdUnder,
  output logic      [9:0]  sfdOver,
  output logic      [9:0]  limitWarn,
  output logic      [9:0]  secondWarn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [39:0] pipe [LAG];
  // comparators settle LAG cycles after a supply moves
  always @(posedge ref_clk) begin
    pipe[0] <= want;
    for (int i = 1; i < LAG; i++) begin
      pipe[i] <= pipe[i-1];
    end
  end
  assign {secondWarn, limitWarn, sfdOver, sfdUnder} = pipe[LAG-1];
endmodule // pse_supply_model
`default_nettype wire

// file: tb/pse_engine_props.sv
`default_nettype none
module pse_engine_props (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [7:0]  araddr,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  // engine outputs
  input wire logic [9:0]  drvOut,
  input wire logic [5:0]  curState
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // answers stand until taken
  property p_bHold;
    bvalid && !bready |=> bvalid;
  endproperty
  a_bHold: assert property (p_bHold) else $error("bvalid dropped");
  property p_rHold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rHold: assert property (p_rHold) else $error("read data moved");
  // refusals while an answer is pending
  property p_wRefuse;
    bvalid |-> !awready && !wready;
  endproperty
  a_wRefuse: assert property (p_wRefuse) else $error("write accepted");
  property p_rRefuse;
    rvalid |-> !arready;
  endproperty
  a_rRefuse: assert property (p_rRefuse) else $error("read accepted");
  // answer latency
  property p_wDone;
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
  endproperty
  a_wDone: assert property (p_wDone) else $error("no write response");
  property p_rDone;
    arvalid && arready |=> rvalid;
  endproperty
  a_rDone: assert property (p_rDone) else $error("no read response");
  property p_unmap;
    arvalid && arready && araddr > 8'h20
      |=> rresp == pse_pkg::RESP_SLVERR && rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read ok");
  // a new definition holds for at least 8 cycles before the next one
  property p_drvHold;
    $changed(drvOut) |=> $stable(drvOut) [*8];
  endproperty
  a_drvHold: assert property (p_drvHold) else $error("drv moved");
  property p_stHold;
    $changed(curState) |=> $stable(curState) [*8];
  endproperty
  a_stHold: assert property (p_stHold) else $error("state moved");
  // main scenarios
  c_unmap: cover property (arvalid && arready && araddr > 8'h20);
  c_state: cover property ($changed(curState));
  c_write: cover property (bvalid && bready);
endmodule // pse_engine_props
bind pse_engine pse_engine_props pse_engine_props_inst (
  .ref_clk, .rstn, .awvalid, .awready, .wvalid, .wready, .bvalid,
  .bready, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
  .rresp, .drvOut, .curState
);
`default_nettype wire

// file: tb/pse_engine_tb.sv
`default_nettype none
module pse_engine_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, rstn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [39:0] want;
  logic [9:0]  sfdUnder, sfdOver, limitWarn, secondWarn, drvOut;
  logic [5:0]  curState;
  int          numErrors;
  int          testsRun;
  pse_engine #(.CLK_PER_US(1)) pse_engine_inst (
    .ref_clk, .rstn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .sfdUnder, .sfdOver,
    .limitWarn, .secondWarn, .drvOut, .curState
  );
  pse_supply_model #(.LAG(2)) pse_supply_model_inst (
    .ref_clk, .want, .sfdUnder, .sfdOver, .limitWarn, .secondWarn
  );
  // bench clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // compare and count
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bus write, both channels offered together
  task automatic wr(logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge ref_clk);
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    chk("bvalid", 32'h1, {31'h0, bvalid});
    chk("bresp", 32'h0, {30'h0, bresp});
  endtask
  // bus read with expected data and response
  task automatic rc(logic [7:0] a, logic [31:0] e, logic [1:0] r);
    int n;
    @(posedge ref_clk);
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", {30'h0, r}, {30'h0, rresp});
  endtask
  // wait for drivers of a state, then confirm the state index
  task automatic wd(logic [9:0] d, logic [5:0] s, int lim);
    int n;
    n = 0;
    while (drvOut !== d && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk("drvOut", {22'h0, d}, {22'h0, drvOut});
    chk("curState", {26'h0, s}, {26'h0, curState});
  endtask
  // definition word, all supply inputs expected ok, warning expected set
  function automatic logic [63:0] mk(logic [9:0] drv, logic [3:0] sel,
      logic [5:0] sn, logic [5:0] mn, logic [5:0] tn, logic [10:0] mask,
      logic [3:0] sd, logic [3:0] td, logic lat);
    return {td, sd, lat, 11'h7ff, mask, tn, mn, sn, 1'b1, sel, drv};
  endfunction
  task automatic def(logic [5:0] i, logic [63:0] w);
    wr(pse_pkg::REG_DEF_IDX, {26'h0, i});
    wr(pse_pkg::REG_DEF_LOW, w[31:0]);
    wr(pse_pkg::REG_DEF_HIGH, w[63:32]);
  endtask
  // live status, reset values, unmapped place
  task automatic testRegs;
    want <= {10'h080, 10'h004, 10'h010, 10'h009};
    repeat (6) @(posedge ref_clk);
    rc(pse_pkg::REG_STAT_SUP, 32'h0010_0009, 2'b00);
    rc(pse_pkg::REG_STAT_LIM, 32'h0080_0004, 2'b00);
    rc(pse_pkg::REG_FLT_LOW, 32'h0, 2'b00);
    rc(8'h40, 32'h0, pse_pkg::RESP_SLVERR);
    want <= 40'h1;
    $display("test regs done");
  endtask
  // qualified sequence exit, then timeout exit
  task automatic testSeq;
    def(6'd0, mk(10'h001, 4'h0, 6'd1, 6'd0, 6'd0, 11'h0, 4'd2, 4'd0, 0));
    def(6'd1, mk(10'h003, 4'hf, 6'd0, 6'd2, 6'd3, 11'h2, 4'd0, 4'd1, 1));
    def(6'd2, mk(10'h100, 4'hf, 6'd0, 6'd0, 6'd3, 11'h0, 4'd0, 4'd0, 0));
    def(6'd3, mk(10'h200, 4'hf, 6'd1, 6'd0, 6'd3, 11'h0, 4'd0, 4'd0, 0));
    wr(pse_pkg::REG_CTRL, 32'h1);
    wd(10'h001, 6'd0, 520);
    want <= 40'h0;
    repeat (15) @(posedge ref_clk);
    want <= 40'h1;
    repeat (2) @(posedge ref_clk);
    want <= 40'h0;
    repeat (15) @(posedge ref_clk);
    want <= 40'h1;
    repeat (530) @(posedge ref_clk);
    chk("drvOut", 32'h001, {22'h0, drvOut});
    want <= 40'h0;
    wd(10'h003, 6'd1, 560);
    repeat (80) @(posedge ref_clk);
    chk("drvOut", 32'h003, {22'h0, drvOut});
    wd(10'h200, 6'd3, 560);
    $display("test seq done");
  endtask
  // host jump, monitor exit and fault latch
  task automatic testJump;
    wr(pse_pkg::REG_CTRL, 32'h3);
    wd(10'h003, 6'd1, 560);
    want <= 40'h2;
    wd(10'h100, 6'd2, 515);
    rc(pse_pkg::REG_FLT_LOW, 32'h2, 2'b00);
    want <= 40'h22;
    repeat (10) @(posedge ref_clk);
    rc(pse_pkg::REG_FLT_LOW, 32'h2, 2'b00);
    wr(pse_pkg::REG_FLT_LOW, 32'h2);
    rc(pse_pkg::REG_FLT_LOW, 32'h0, 2'b00);
    $display("test jump done");
  endtask
  // warning offered to the timeout path
  task automatic testWarn;
    want <= 40'h0000100000;
    wd(10'h200, 6'd3, 520);
    rc(pse_pkg::REG_CTRL, 32'h1, 2'b00);
    $display("test warn done");
  endtask
  // verdict
  task automatic testDone;
    $display("checks %0d errors %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 48'h0;
    want = 40'h1;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    testRegs;
    testSeq;
    testJump;
    testWarn;
    testDone;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    numErrors++;
    testDone;
  end
endmodule // pse_engine_tb
`default_nettype wire
